// [hw/adcts_top.sv]
// trigger source selection for sample sequencers 0 and 1, APB slave
// assumes pclk at 125 MHz, sources synchronous to pclk, and that the
// timer and pwm blocks supply their trigger enables as levels
`timescale 1ns/1ps
`include "adcts_regs.svh"

// Operation
// - seq1 select field bits 7:4, resets zero
// - seq0 select field bits 3:0, resets zero
// - decode software, comparator, pin, continuous codes
// - code five: timer, needs timer trigger enable
// - code six: pwm generator 0 trigger
// - code seven: pwm generator 1 trigger
// - code eight: pwm generator 2 trigger
module adcts_top
  import adcts_pkg::*;
#(
  parameter int NUM_SEQ = 2,    // sequencers served by this block
  parameter int ADDR_W = 12     // apb address width
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SEQ-1:0] sw_start,
  input wire logic comp0_trig,
  input wire logic external_trigger_pin,
  input wire logic timer_trig,
  input wire logic timer_output_trigger_en,
  input wire logic [2:0] pwm_trig,
  input wire logic pwm_gen0_int_trig_enable,
  input wire logic pwm_gen1_int_trig_enable,
  input wire logic pwm_gen2_int_trig_enable,
  output logic [NUM_SEQ-1:0] seq_start
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // field layout only has room for the two lowest sequencers
  if (NUM_SEQ != 2)
  begin : g_bad_seq
    $error("adcts_top: NUM_SEQ must be 2");
  end
  if (ADDR_W < 12)
  begin : g_bad_addr
    $error("adcts_top: ADDR_W must be at least 12");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adcts_sel_t sel_q [NUM_SEQ];          // per-sequencer select field
  logic [NUM_SEQ-1:0] start_q;          // registered start triggers
  logic [NUM_SEQ-1:0] rsv_q;            // reserved code in use
  logic [NUM_SEQ-1:0] trig_d;           // decoded trigger, next value
  logic [NUM_SEQ-1:0] rsv_d;            // decoded reserved flag
  logic pready_q;                       // access answer
  logic pslverr_q;                      // unmapped address answer
  logic [31:0] prdata_q;                // captured read data
  logic [31:0] rdata_d;                 // read mux
  logic hit_sel;                        // address decodes select reg
  logic hit_stat;                       // address decodes status reg
  logic acc_first;                      // first access cycle
  logic acc_done;                       // completing access edge
  logic wr_sel;                         // write to select, lane 0
  adcts_src_t src;                      // qualified common sources

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state so that every bus output is a flip-flop
  assign hit_sel = (paddr[`ADCTS_DEC_MSB:0] == `ADCTS_SEL_OFS);
  assign hit_stat = (paddr[`ADCTS_DEC_MSB:0] == `ADCTS_STAT_OFS);
  assign acc_first = psel & penable & ~pready_q;
  assign acc_done = psel & penable & pready_q;
  // fields live in byte lane 0 only; other lanes are ignored
  assign wr_sel = acc_done & pwrite & hit_sel & pstrb[0];

  // ----------------------------------------------------------------
  // source qualification
  // ----------------------------------------------------------------
  // enables are gated here so the decoder sees one line per code
  always_comb
  begin
    src.comp0 = comp0_trig;
    src.ext = external_trigger_pin;
    src.timer = timer_trig & timer_output_trigger_en;
    src.pwm[0] = pwm_trig[0] & pwm_gen0_int_trig_enable;
    src.pwm[1] = pwm_trig[1] & pwm_gen1_int_trig_enable;
    src.pwm[2] = pwm_trig[2] & pwm_gen2_int_trig_enable;
  end

  // ----------------------------------------------------------------
  // per-sequencer select field and decoder
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_SEQ; i++)
  begin : g_seq
    // field position: seq0 bits 3:0, seq1 bits 7:4
    localparam int LSB = (i == 0) ? `ADCTS_SEL0_LSB : `ADCTS_SEL1_LSB;

    // select field, written on the completing edge only
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        sel_q[i] <= `ADCTS_SEL_RST;
      end
      else if (wr_sel)
      begin
        sel_q[i] <= pwdata[LSB +: `ADCTS_SEL_W];
      end
    end

    // source decode for this sequencer
    adcts_trig_mux u_mux (
      .sel(sel_q[i]),
      .sw_start(sw_start[i]),
      .src(src),
      .trig(trig_d[i]),
      .rsv(rsv_d[i])
    );
  end

  // ----------------------------------------------------------------
  // start trigger outputs
  // ----------------------------------------------------------------
  // registered, so a source reaches the sequencer one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= '0;
      rsv_q <= '0;
    end
    else
    begin
      start_q <= trig_d;
      rsv_q <= rsv_d;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // reserved bits and unmapped addresses read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hit_sel)
    begin
      rdata_d[`ADCTS_SEL0_LSB +: `ADCTS_SEL_W] = sel_q[0];
      rdata_d[`ADCTS_SEL1_LSB +: `ADCTS_SEL_W] = sel_q[1];
    end
    else if (hit_stat)
    begin
      rdata_d[`ADCTS_STAT_START_LSB +: NUM_SEQ] = start_q;
      rdata_d[`ADCTS_STAT_RSV_LSB +: NUM_SEQ] = rsv_q;
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // pready rises in the second access cycle and stays one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc_first;
      // error only for unmapped addresses; writes to status are ignored
      pslverr_q <= acc_first & ~(hit_sel | hit_stat);
      if (acc_first & ~pwrite)
      begin
        prdata_q <= rdata_d;
      end
      else
      begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign seq_start = start_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // a write to the select register lands in seq1's field next cycle
  property p_wr_seq1;
    @(posedge pclk) disable iff (!presetn)
    wr_sel |=> (sel_q[1] == $past(pwdata[`ADCTS_SEL1_LSB +: `ADCTS_SEL_W]));
  endproperty
  a_wr_seq1: assert property (p_wr_seq1)
    else $error("seq1 select field not written");

  // seq0 field follows bits 3:0 and reads back on the bus
  property p_rd_seq0;
    @(posedge pclk) disable iff (!presetn)
    (acc_first & ~pwrite & hit_sel)
      |=> (prdata[`ADCTS_SEL0_LSB +: `ADCTS_SEL_W] == sel_q[0]) && pready;
  endproperty
  a_rd_seq0: assert property (p_rd_seq0)
    else $error("seq0 select field read back wrong");

  // software code passes the processor start through in one cycle
  property p_sw;
    @(posedge pclk) disable iff (!presetn)
    (sel_q[0] == `ADCTS_CODE_SW) && sw_start[0] |=> seq_start[0];
  endproperty
  a_sw: assert property (p_sw)
    else $error("software start not passed to sequencer 0");

  // continuous code holds the start high for as long as it stays
  property p_always;
    @(posedge pclk) disable iff (!presetn)
    (sel_q[1] == `ADCTS_CODE_ALWAYS)[*2] |=> seq_start[1];
  endproperty
  a_always: assert property (p_always)
    else $error("continuous sampling start missing");

  // timer trigger without its enable never starts a sequencer
  property p_timer;
    @(posedge pclk) disable iff (!presetn)
    (sel_q[0] == `ADCTS_CODE_TIMER)
      |=> (seq_start[0] == $past(timer_trig & timer_output_trigger_en));
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer trigger not qualified by its enable");

  // pwm generator 0 trigger follows its enable
  property p_pwm0;
    @(posedge pclk) disable iff (!presetn)
    (sel_q[1] == `ADCTS_CODE_PWM0)
      |=> (seq_start[1] == $past(pwm_trig[0] & pwm_gen0_int_trig_enable));
  endproperty
  a_pwm0: assert property (p_pwm0)
    else $error("pwm0 trigger routing wrong");

  // pwm generator 1 trigger follows its enable
  property p_pwm1;
    @(posedge pclk) disable iff (!presetn)
    (sel_q[0] == `ADCTS_CODE_PWM1)
      |=> (seq_start[0] == $past(pwm_trig[1] & pwm_gen1_int_trig_enable));
  endproperty
  a_pwm1: assert property (p_pwm1)
    else $error("pwm1 trigger routing wrong");

  // pwm generator 2 trigger follows its enable
  property p_pwm2;
    @(posedge pclk) disable iff (!presetn)
    (sel_q[1] == `ADCTS_CODE_PWM2)
      |=> (seq_start[1] == $past(pwm_trig[2] & pwm_gen2_int_trig_enable));
  endproperty
  a_pwm2: assert property (p_pwm2)
    else $error("pwm2 trigger routing wrong");

  // reserved codes keep the start low and flag the status
  property p_rsv;
    @(posedge pclk) disable iff (!presetn)
    ((sel_q[0] == `ADCTS_CODE_RSV2) || (sel_q[0] == `ADCTS_CODE_RSV3) ||
     (sel_q[0] >= `ADCTS_CODE_RSV_LO && sel_q[0] <= `ADCTS_CODE_RSV_HI))
      |=> !seq_start[0] && rsv_q[0];
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved code produced a trigger");

  // reserved codes on sequencer 1 behave as on sequencer 0
  property p_rsv1;
    @(posedge pclk) disable iff (!presetn)
    ((sel_q[1] == `ADCTS_CODE_RSV2) || (sel_q[1] == `ADCTS_CODE_RSV3) ||
     (sel_q[1] >= `ADCTS_CODE_RSV_LO && sel_q[1] <= `ADCTS_CODE_RSV_HI))
      |=> !seq_start[1] && rsv_q[1];
  endproperty
  a_rsv1: assert property (p_rsv1)
    else $error("reserved code on sequencer 1 produced a trigger");

  // comparator code routes comparator 0 to sequencer 0
  property p_comp0;
    @(posedge pclk) disable iff (!presetn)
    (sel_q[0] == `ADCTS_CODE_COMP0) |=> (seq_start[0] == $past(comp0_trig));
  endproperty
  a_comp0: assert property (p_comp0)
    else $error("comparator trigger not passed to sequencer 0");

  // pin code routes the external trigger pin to sequencer 1
  property p_ext;
    @(posedge pclk) disable iff (!presetn)
    (sel_q[1] == `ADCTS_CODE_EXT) |=> (seq_start[1] == $past(external_trigger_pin));
  endproperty
  a_ext: assert property (p_ext)
    else $error("external pin trigger not passed to sequencer 1");

endmodule : adcts_top

// [hw/adcts_regs.svh]
// register offsets, field positions, reset values and select codes
// assumes a 12-bit APB byte address and 32-bit data
`ifndef ADCTS_REGS_SVH
`define ADCTS_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADCTS_SEL_OFS 12'h000
`define ADCTS_STAT_OFS 12'h004
// top bit of the decoded part of the byte address
`define ADCTS_DEC_MSB 11

// ----------------------------------------------------------------
// field layout of the select register
// ----------------------------------------------------------------
`define ADCTS_SEL0_LSB 0
`define ADCTS_SEL1_LSB 4
`define ADCTS_SEL_W 4
`define ADCTS_SEL_RST 4'h0

// ----------------------------------------------------------------
// field layout of the status register
// ----------------------------------------------------------------
`define ADCTS_STAT_START_LSB 0
`define ADCTS_STAT_RSV_LSB 2

// ----------------------------------------------------------------
// trigger select codes
// ----------------------------------------------------------------
`define ADCTS_CODE_SW 4'h0
`define ADCTS_CODE_COMP0 4'h1
`define ADCTS_CODE_RSV2 4'h2
`define ADCTS_CODE_RSV3 4'h3
`define ADCTS_CODE_EXT 4'h4
`define ADCTS_CODE_TIMER 4'h5
`define ADCTS_CODE_PWM0 4'h6
`define ADCTS_CODE_PWM1 4'h7
`define ADCTS_CODE_PWM2 4'h8
`define ADCTS_CODE_ALWAYS 4'hF
// upper reserved band, both ends included
`define ADCTS_CODE_RSV_LO 4'h9
`define ADCTS_CODE_RSV_HI 4'hE

`endif

// [hw/adcts_pkg.sv]
// types shared by the trigger select block and its decoder
// assumes adcts_regs.svh for all numeric values
package adcts_pkg;

  // one 4-bit trigger select field
  typedef logic [3:0] adcts_sel_t;

  // trigger sources common to every sequencer
  typedef struct packed {
    logic comp0;       // analog comparator 0 trigger
    logic ext;         // external trigger pin
    logic timer;       // timer trigger, already qualified by its enable
    logic [2:0] pwm;   // pwm generator triggers, already qualified
  } adcts_src_t;

endpackage : adcts_pkg

// [hw/adcts_trig_mux.sv]
// one sequencer's trigger source decoder, purely combinational
// assumes qualified sources; the caller registers the result
`timescale 1ns/1ps
`include "adcts_regs.svh"

module adcts_trig_mux
  import adcts_pkg::*;
(
  input wire adcts_sel_t sel,
  input wire logic sw_start,
  input wire adcts_src_t src,
  output logic trig,
  output logic rsv
);

  // ----------------------------------------------------------------
  // select decode
  // ----------------------------------------------------------------
  // reserved codes give no trigger and raise rsv
  always_comb
  begin
    trig = 1'b0;
    rsv = 1'b0;
    case (sel)
      `ADCTS_CODE_SW: trig = sw_start;
      `ADCTS_CODE_COMP0: trig = src.comp0;
      `ADCTS_CODE_EXT: trig = src.ext;
      `ADCTS_CODE_TIMER: trig = src.timer;
      `ADCTS_CODE_PWM0: trig = src.pwm[0];
      `ADCTS_CODE_PWM1: trig = src.pwm[1];
      `ADCTS_CODE_PWM2: trig = src.pwm[2];
      `ADCTS_CODE_ALWAYS: trig = 1'b1;
      default: rsv = 1'b1;
    endcase
  end

endmodule : adcts_trig_mux

// [test/adcts_src_model.sv]
// behavioural model of the timer, comparator, pin and pwm trigger sources
// assumes the bench loads a source pattern with a one-cycle ld strobe
`timescale 1ns/1ps

module adcts_src_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ld,
  input wire logic [9:0] pat,
  output logic comp0_trig,
  output logic external_trigger_pin,
  output logic timer_trig,
  output logic timer_output_trigger_en,
  output logic [2:0] pwm_trig,
  output logic pwm_gen0_int_trig_enable,
  output logic pwm_gen1_int_trig_enable,
  output logic pwm_gen2_int_trig_enable
);
  // ----------------------------------------------------------------
  // source levels
  // ----------------------------------------------------------------
  // all sources low in reset; a new pattern lands one edge after ld
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {pwm_gen2_int_trig_enable, pwm_gen1_int_trig_enable, pwm_gen0_int_trig_enable,
       pwm_trig, timer_output_trigger_en, timer_trig, external_trigger_pin,
       comp0_trig} <= 10'h000;
    end
    else if (ld)
    begin
      // timer trigger and its enable stay separate levels, qualified downstream
      {pwm_gen2_int_trig_enable, pwm_gen1_int_trig_enable, pwm_gen0_int_trig_enable,
       pwm_trig, timer_output_trigger_en, timer_trig, external_trigger_pin,
       comp0_trig} <= pat;
    end
  end
endmodule : adcts_src_model

// [test/adc_sequencer_trigger_select_tb.sv]
// self-checking bench for the sequencer trigger select block
// assumes one wait state apb answers and seq_start one clock after its source
`timescale 1ns/1ps
`include "adcts_regs.svh"

module adc_sequencer_trigger_select_tb;
  // ----------------------------------------------------------------
  // stimulus and bookkeeping
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, ld, look;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, w;
  logic [3:0] pstrb;
  logic pready, pslverr;
  logic [1:0] sw_start, seq_start, sw, e;
  logic comp0_trig, ext_pin, timer_trig, timer_en, pen0, pen1, pen2;
  logic [2:0] pwm_trig;
  logic [9:0] pat, v;
  logic [3:0] c0, c1;
  logic [32:0] qa[$]; // expected {pslverr, prdata} per apb answer
  logic [1:0] qt[$]; // expected seq_start per trigger check
  int n_fail, n_tests;

  adcts_top #(.NUM_SEQ(2), .ADDR_W(12)) i_adcts_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_start(sw_start), .comp0_trig(comp0_trig), .external_trigger_pin(ext_pin),
    .timer_trig(timer_trig), .timer_output_trigger_en(timer_en), .pwm_trig(pwm_trig),
    .pwm_gen0_int_trig_enable(pen0), .pwm_gen1_int_trig_enable(pen1),
    .pwm_gen2_int_trig_enable(pen2), .seq_start(seq_start));

  adcts_src_model i_adcts_src_model (.pclk(pclk), .presetn(presetn), .ld(ld), .pat(pat),
    .comp0_trig(comp0_trig), .external_trigger_pin(ext_pin), .timer_trig(timer_trig),
    .timer_output_trigger_en(timer_en), .pwm_trig(pwm_trig),
    .pwm_gen0_int_trig_enable(pen0), .pwm_gen1_int_trig_enable(pen1),
    .pwm_gen2_int_trig_enable(pen2));

  // 125 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected start for one sequencer; pattern bits are the model's order
  function automatic logic exp_trig(input logic [3:0] code, input logic s,
                                    input logic [9:0] p);
    case (code)
      `ADCTS_CODE_SW: exp_trig = s;
      `ADCTS_CODE_COMP0: exp_trig = p[0];
      `ADCTS_CODE_EXT: exp_trig = p[1];
      `ADCTS_CODE_TIMER: exp_trig = p[2] & p[3];
      `ADCTS_CODE_PWM0: exp_trig = p[4] & p[7];
      `ADCTS_CODE_PWM1: exp_trig = p[5] & p[8];
      `ADCTS_CODE_PWM2: exp_trig = p[6] & p[9];
      `ADCTS_CODE_ALWAYS: exp_trig = 1'b1;
      default: exp_trig = 1'b0;
    endcase
  endfunction : exp_trig

  // reserved codes flag the status register
  function automatic logic exp_rsv(input logic [3:0] code);
    exp_rsv = (code == `ADCTS_CODE_RSV2) || (code == `ADCTS_CODE_RSV3) ||
              (code >= `ADCTS_CODE_RSV_LO && code <= `ADCTS_CODE_RSV_HI);
  endfunction : exp_rsv

  task automatic note_fail(input string m);
    n_fail++;
    $display("Error at %0t: %s", $time, m);
  endtask : note_fail

  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // one apb transfer, entered just after a rising edge; one idle edge after
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st, input logic [32:0] e);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    qa.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 16)
    begin
      note_fail("apb answer missing");
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // load a source pattern and request level, then look at seq_start
  task automatic src(input logic [9:0] p, input logic [1:0] s, input logic [1:0] e);
    ld <= 1'b1;
    pat <= p;
    @(posedge pclk);
    ld <= 1'b0;
    sw_start <= s;
    qt.push_back(e);
    @(posedge pclk);
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask : src

  // ----------------------------------------------------------------
  // result watcher: oldest note against each answer
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (presetn === 1'b1 && pready === 1'b1)
    begin
      n_tests++;
      if (qa.size() == 0)
        note_fail("unexpected apb answer");
      else if ({pslverr, prdata} !== qa.pop_front())
        note_fail("apb answer differs");
    end
    if (look === 1'b1)
    begin
      n_tests++;
      if (qt.size() == 0)
        note_fail("unexpected trigger check");
      else if (seq_start !== qt.pop_front())
        note_fail("sequencer start differs");
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    n_tests = 0;
    {presetn, psel, penable, pwrite, ld, look} = 6'h00;
    {paddr, pwdata, pstrb, pat, sw_start} = 60'h0;
    void'($urandom(4194));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ADCTS_SEL_OFS, 32'h0, 4'hF, 33'h0);
    apb(1'b0, 12'h008, 32'h0, 4'hF, {1'b1, 32'h0});
    apb(1'b1, 12'h008, 32'hFF, 4'hF, {1'b1, 32'h0});
    apb(1'b1, `ADCTS_SEL_OFS, 32'hFF, 4'h0, 33'h0);
    apb(1'b0, `ADCTS_SEL_OFS, 32'h0, 4'hF, 33'h0);
    apb(1'b1, `ADCTS_STAT_OFS, 32'hF, 4'hF, 33'h0);
    // every code on seq0, its complement on seq1
    for (int c = 0; c < 16; c++)
    begin
      c0 = 4'(c);
      c1 = ~c0;
      w = $urandom;
      apb(1'b1, `ADCTS_SEL_OFS, {w[31:8], c1, c0}, 4'hF, 33'h0);
      apb(1'b0, `ADCTS_SEL_OFS, 32'h0, 4'hF, {9'h0, 16'h0, c1, c0});
      for (int i = 0; i < 9; i++)
      begin
        v = (i == 0) ? 10'h3FF : 10'($urandom);
        sw = (i == 0) ? 2'h3 : 2'($urandom);
        e = {exp_trig(c1, sw[1], v), exp_trig(c0, sw[0], v)};
        src(v, sw, e);
      end
      // sources still stand, so the status shows the last starts
      apb(1'b0, `ADCTS_STAT_OFS, 32'h0, 4'hF, {29'h0, exp_rsv(c1), exp_rsv(c0), e});
    end
    // reset in mid-run: both fields fall back to code zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ADCTS_SEL_OFS, 32'h0, 4'hF, 33'h0);
    if (qa.size() != 0 || qt.size() != 0)
      note_fail("expected results left over");
    tally_and_finish();
  end
endmodule : adc_sequencer_trigger_select_tb
